/* File: rtl/rcfc_pkg.sv */
package rcfc_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_HZ          = 10_000_000;
  localparam int unsigned ARM_TIMEOUT_S   = 5;
  localparam int unsigned STEP_TIMEOUT_S  = 20;
  localparam int unsigned DEBOUNCE_MS     = 20;
  localparam int unsigned DOUBLE_GAP_MS   = 500;
  localparam int unsigned ARM_TIMEOUT_CYC  = ARM_TIMEOUT_S * CLK_HZ;
  localparam int unsigned STEP_TIMEOUT_CYC = STEP_TIMEOUT_S * CLK_HZ;
  localparam int unsigned DEBOUNCE_CYC     = DEBOUNCE_MS * (CLK_HZ / 1000);
  localparam int unsigned DOUBLE_GAP_CYC   = DOUBLE_GAP_MS * (CLK_HZ / 1000);
  localparam int unsigned TMR_W            = 28;
  localparam int unsigned DB_W             = 20;

  // ----------------------------------------------------------------
  // Display and fault codes
  // ----------------------------------------------------------------
  localparam logic [3:0] DISP_NORMAL = 4'h0;
  localparam logic [3:0] DISP_CAL    = 4'h1;
  localparam logic [3:0] DISP_SET1   = 4'h2;
  localparam logic [3:0] DISP_SET2   = 4'h3;
  localparam logic [3:0] DISP_RPM    = 4'h4;
  localparam logic [3:0] FAULT_NONE     = 4'h0;
  localparam logic [3:0] FAULT_NO_RPM   = 4'h3;
  localparam logic [3:0] FAULT_NO_PRESS = 4'h7;

  localparam logic [15:0] RPM_STEP  = 16'h0001;
  localparam logic [15:0] TRIM_ZERO = 16'h0000;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic idle;
    logic preset;
    logic increase;
    logic decrease;
    logic mode;
    logic rpm;
  } rcfc_btn_t;

  typedef enum logic [2:0] {
    SPD_HOLD,
    SPD_IDLE,
    SPD_CAL1,
    SPD_CAL2,
    SPD_HIGH_IDLE
  } rcfc_speed_t;

  typedef struct packed {
    logic [3:0]  code;
    logic        flash;
    logic        pressMode;
    logic        rpmMode;
    logic        highIdleLamp;
  } rcfc_panel_t;

endpackage

/* File: rtl/rcfc_debounce.sv */
`timescale 1ns/100ps
`default_nettype none

module rcfc_debounce
#(
  parameter int unsigned DEBOUNCE_CYC = rcfc_pkg::DEBOUNCE_CYC
)
(
  input  wire logic clk,
  input  wire logic sys_rst,
  input  wire logic rawIn,
  output logic      pressPulse
);

  logic                       sync1_q;
  logic                       sync2_q;
  logic                       stable_q;
  logic [rcfc_pkg::DB_W-1:0]  cnt_q;
  logic                       differ;
  logic                       settled;

  assign differ  = sync2_q != stable_q;
  assign settled = cnt_q == rcfc_pkg::DB_W'(DEBOUNCE_CYC - 1);

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      sync1_q    <= 1'b0;
      sync2_q    <= 1'b0;
      stable_q   <= 1'b0;
      cnt_q      <= '0;
      pressPulse <= 1'b0;
    end
    else
    begin
      sync1_q    <= rawIn;
      sync2_q    <= sync1_q;
      pressPulse <= 1'b0;
      if (!differ)
        cnt_q <= '0;
      else if (settled)
      begin
        cnt_q      <= '0;
        stable_q   <= sync2_q;
        pressPulse <= sync2_q; // R15
      end
      else
        cnt_q <= cnt_q + 1'b1;
    end
  end

endmodule
`default_nettype wire

/* File: rtl/rcfc_sequencer.sv */
// Functional notes
// R1: RPM button selects RPM mode, red lamp
// R2: Double idle press arms, CAL flashes (code arms only while RPM mode is selected)
// R3: Second double press confirms, CAL steady
// R4: Five seconds without confirm abandons calibration (code restarts the five seconds on a press of any button)
// R5: First preset drives speed one, Set1
// R6: Next preset shows RPM, buttons trim
// R7: Twenty seconds without press exits calibration
// R8: Preset after point one drives speed two
// R9: Next preset shows RPM, buttons trim
// R10: Final preset ends, keeps trims, idles
// R11: High idle switch lights lamp, pot speed
// R12: Missing RPM data gives fault E3
// R13: Pressure not reaching set gives E7
// R14: Mode button toggles pressure and RPM (code ignores the mode button whenever state_d is not S_NORMAL)
// R15: Buttons synchronised, debounced, one press each
// R16: Double press only within bounded gap
`timescale 1ns/100ps
`default_nettype none

module rcfc_sequencer
#(
  parameter int unsigned DEBOUNCE_CYC     = rcfc_pkg::DEBOUNCE_CYC,
  parameter int unsigned DOUBLE_GAP_CYC   = rcfc_pkg::DOUBLE_GAP_CYC,
  parameter int unsigned ARM_TIMEOUT_CYC  = rcfc_pkg::ARM_TIMEOUT_CYC,
  parameter int unsigned STEP_TIMEOUT_CYC = rcfc_pkg::STEP_TIMEOUT_CYC
)
(
  input  wire logic               clk,
  input  wire logic               sys_rst,
  input  wire rcfc_pkg::rcfc_btn_t btnRaw,
  input  wire logic               highIdleSw,
  input  wire logic [15:0]        highIdlePot,
  input  wire logic               rpmDataSeen,
  input  wire logic               pressLow,
  output rcfc_pkg::rcfc_panel_t   panel_q,
  output rcfc_pkg::rcfc_speed_t   speedCmd_q,
  output logic [15:0]             speedTarget_q,
  output logic [15:0]             trim1_q,
  output logic [15:0]             trim2_q,
  output logic [3:0]              faultCode_q
);

  // ----------------------------------------------------------------
  // Button press events
  // ----------------------------------------------------------------
  logic [5:0] btnVec;
  logic [5:0] pressVec;
  assign btnVec = btnRaw;

  genvar gi;
  generate
    for (gi = 0; gi < 6; gi++)
    begin : g_db
      rcfc_debounce #(.DEBOUNCE_CYC (DEBOUNCE_CYC)) u_db
      (
        .clk        (clk),
        .sys_rst    (sys_rst),
        .rawIn      (btnVec[gi]),
        .pressPulse (pressVec[gi])
      );
    end
  endgenerate

  rcfc_pkg::rcfc_btn_t press;
  assign press = pressVec;

  logic hiSync1_q;
  logic hiSync2_q;
  logic rpmSync1_q;
  logic rpmSync2_q;
  logic plSync1_q;
  logic plSync2_q;
  // Pot word is resampled every cycle, so a torn sample lasts one cycle
  logic [15:0] potSync1_q;
  logic [15:0] potSync2_q;

  // ----------------------------------------------------------------
  // Double press detection on idle
  // ----------------------------------------------------------------
  logic                        idlePend_q;
  logic [rcfc_pkg::TMR_W-1:0]  gap_q;
  logic                        gapExpired;
  logic                        idleDouble;
  assign gapExpired = gap_q == rcfc_pkg::TMR_W'(DOUBLE_GAP_CYC - 1);
  assign idleDouble = press.idle && idlePend_q; // R16

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    S_NORMAL,
    S_ARMED,
    S_CAL,
    S_P1_SET,
    S_P1_ADJ,
    S_P2_SET,
    S_P2_ADJ
  } rcfc_state_t;

  rcfc_state_t                state_q;
  rcfc_state_t                state_d;
  logic                       rpmMode_q;
  logic [rcfc_pkg::TMR_W-1:0] tmr_q;
  logic                       anyPress;
  logic                       inSteps;
  logic                       armTimeout;
  logic                       stepTimeout;
  logic                       adjP1;
  logic                       adjP2;
  logic [15:0]                trimDelta;

  assign anyPress    = |pressVec;
  assign inSteps     = state_q != S_NORMAL && state_q != S_ARMED;
  assign armTimeout  = state_q == S_ARMED
                       && tmr_q == rcfc_pkg::TMR_W'(ARM_TIMEOUT_CYC - 1); // R4
  assign stepTimeout = inSteps
                       && tmr_q == rcfc_pkg::TMR_W'(STEP_TIMEOUT_CYC - 1); // R7
  assign adjP1       = state_q == S_P1_ADJ;
  assign adjP2       = state_q == S_P2_ADJ;
  assign trimDelta   = press.increase ? rcfc_pkg::RPM_STEP
                     : press.decrease ? -rcfc_pkg::RPM_STEP : rcfc_pkg::TRIM_ZERO;

  always_comb
  begin
    state_d = state_q;
    case (state_q)
      S_NORMAL:
        if (idleDouble && rpmMode_q)
          state_d = S_ARMED; // R2
      S_ARMED:
        if (armTimeout)
          state_d = S_NORMAL; // R4
        else if (idleDouble)
          state_d = S_CAL; // R3
      S_CAL:
        if (press.preset)
          state_d = S_P1_SET; // R5
      S_P1_SET:
        if (press.preset)
          state_d = S_P1_ADJ; // R6
      S_P1_ADJ:
        if (press.preset)
          state_d = S_P2_SET; // R8
      S_P2_SET:
        if (press.preset)
          state_d = S_P2_ADJ; // R9
      S_P2_ADJ:
        if (press.preset)
          state_d = S_NORMAL; // R10
      default:
        state_d = S_NORMAL;
    endcase
    if (stepTimeout)
      state_d = S_NORMAL; // R7
  end

  // ----------------------------------------------------------------
  // Panel decode
  // ----------------------------------------------------------------
  logic [3:0]            dispCode;
  rcfc_pkg::rcfc_speed_t speedSel;
  logic                  nextRpmMode;
  logic                  calActive;

  assign calActive   = state_d != S_NORMAL;
  assign nextRpmMode = press.rpm ? 1'b1                           // R1
                     : (press.mode && !calActive) ? !rpmMode_q    // R14
                     : rpmMode_q;
  always_comb
  begin
    case (state_d)
      S_ARMED, S_CAL: dispCode = rcfc_pkg::DISP_CAL;
      S_P1_SET:       dispCode = rcfc_pkg::DISP_SET1;
      S_P2_SET:       dispCode = rcfc_pkg::DISP_SET2;
      S_P1_ADJ,
      S_P2_ADJ:       dispCode = rcfc_pkg::DISP_RPM;
      default:        dispCode = rcfc_pkg::DISP_NORMAL;
    endcase
  end

  // Calibration owns the engine; high idle only applies outside it
  always_comb
  begin
    case (state_d)
      S_P1_SET, S_P1_ADJ: speedSel = rcfc_pkg::SPD_CAL1; // R5
      S_P2_SET, S_P2_ADJ: speedSel = rcfc_pkg::SPD_CAL2; // R8
      S_ARMED, S_CAL:     speedSel = rcfc_pkg::SPD_HOLD;
      default:
        speedSel = hiSync2_q ? rcfc_pkg::SPD_HIGH_IDLE // R11
                 : (state_q == S_P2_ADJ) ? rcfc_pkg::SPD_IDLE // R10
                 : (inSteps || speedCmd_q == rcfc_pkg::SPD_HIGH_IDLE)
                 ? rcfc_pkg::SPD_IDLE : speedCmd_q;
    endcase
  end

  logic [3:0] faultNext;
  assign faultNext = !rpmSync2_q ? rcfc_pkg::FAULT_NO_RPM   // R12
                   : plSync2_q   ? rcfc_pkg::FAULT_NO_PRESS // R13
                   : rcfc_pkg::FAULT_NONE;

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      hiSync1_q  <= 1'b0;
      hiSync2_q  <= 1'b0;
      rpmSync1_q <= 1'b1;
      rpmSync2_q <= 1'b1;
      plSync1_q  <= 1'b0;
      plSync2_q  <= 1'b0;
      potSync1_q <= '0;
      potSync2_q <= '0;
    end
    else
    begin
      hiSync1_q  <= highIdleSw;
      hiSync2_q  <= hiSync1_q;
      rpmSync1_q <= rpmDataSeen;
      rpmSync2_q <= rpmSync1_q;
      plSync1_q  <= pressLow;
      plSync2_q  <= plSync1_q;
      potSync1_q <= highIdlePot;
      potSync2_q <= potSync1_q;
    end
  end

  // A lone idle press is dropped once the gap runs out
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      idlePend_q <= 1'b0;
      gap_q      <= '0;
    end
    else if (press.idle)
    begin
      idlePend_q <= !idlePend_q; // R16
      gap_q      <= '0;
    end
    else if (idlePend_q)
    begin
      idlePend_q <= !gapExpired; // R16
      gap_q      <= gap_q + 1'b1;
    end
  end

  // Any press restarts the timeout; confirmation waits are press driven
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      tmr_q <= '0;
    else if (state_d != state_q || anyPress)
      tmr_q <= '0;
    else if (state_q != S_NORMAL)
      tmr_q <= tmr_q + 1'b1;
  end

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      state_q       <= S_NORMAL;
      rpmMode_q     <= 1'b0;
      panel_q       <= '0;
      speedCmd_q    <= rcfc_pkg::SPD_HOLD;
      speedTarget_q <= '0;
      trim1_q       <= '0;
      trim2_q       <= '0;
      faultCode_q   <= rcfc_pkg::FAULT_NONE;
    end
    else
    begin
      state_q                <= state_d;
      rpmMode_q              <= nextRpmMode;
      panel_q.code           <= dispCode;
      panel_q.flash          <= state_d == S_ARMED; // R2 R3
      panel_q.rpmMode        <= nextRpmMode;        // R1
      panel_q.pressMode      <= !nextRpmMode;       // R14
      panel_q.highIdleLamp   <= hiSync2_q;          // R11
      speedCmd_q             <= speedSel;
      speedTarget_q          <= hiSync2_q ? potSync2_q : speedTarget_q; // R11
      faultCode_q            <= faultNext;
      if (adjP1)
        trim1_q <= trim1_q + trimDelta; // R6
      if (adjP2)
        trim2_q <= trim2_q + trimDelta; // R9
    end
  end

endmodule
`default_nettype wire

/* File: testbench/rcfc_ecu_model.sv */
`timescale 1ns/100ps
`default_nettype none

module rcfc_ecu_model
(
  input  wire logic clk,
  input  wire logic sys_rst,
  input  wire logic dropData,
  input  wire logic weakPump,
  output logic      rpmDataSeen,
  output logic      pressLow
);
  // Link silent until the engine reports; a weak pump never builds pressure
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      rpmDataSeen <= 1'b0;
      pressLow    <= 1'b0;
    end
    else
    begin
      rpmDataSeen <= !dropData;
      pressLow    <= weakPump;
    end
  end
endmodule

`default_nettype wire

/* File: testbench/rcfc_seq_chk.sv */
`timescale 1ns/100ps
`default_nettype none

module rcfc_seq_chk
(
  input wire logic                  clk,
  input wire logic                  sys_rst,
  input wire logic                  highIdleSw,
  input wire logic [15:0]           highIdlePot,
  input wire logic                  rpmDataSeen,
  input wire logic                  pressLow,
  input wire rcfc_pkg::rcfc_panel_t panel_q,
  input wire rcfc_pkg::rcfc_speed_t speedCmd_q,
  input wire logic [15:0]           speedTarget_q,
  input wire logic [15:0]           trim1_q,
  input wire logic [3:0]            faultCode_q
);
  default clocking @(posedge clk);
  endclocking
  default disable iff (sys_rst);

  AST_FLASH_ARMED: assert property (panel_q.flash |-> panel_q.code == rcfc_pkg::DISP_CAL)
    else $error("flash outside arming");
  AST_SET1_SPEED: assert property (panel_q.code == rcfc_pkg::DISP_SET1
    |-> speedCmd_q == rcfc_pkg::SPD_CAL1) else $error("point one speed wrong");
  AST_SET2_SPEED: assert property (panel_q.code == rcfc_pkg::DISP_SET2
    |-> speedCmd_q == rcfc_pkg::SPD_CAL2) else $error("point two speed wrong");
  AST_ONE_LAMP: assert property (1'b1 |-> ##1 panel_q.pressMode != panel_q.rpmMode)
    else $error("mode lamps disagree");
  AST_NO_RPM: assert property ((!rpmDataSeen)[*5] |-> faultCode_q == rcfc_pkg::FAULT_NO_RPM)
    else $error("missing rpm fault");
  AST_NO_PRESS: assert property ((rpmDataSeen && pressLow)[*5]
    |-> faultCode_q == rcfc_pkg::FAULT_NO_PRESS) else $error("missing pressure fault");
  AST_NO_FAULT: assert property ((rpmDataSeen && !pressLow)[*5]
    |-> faultCode_q == rcfc_pkg::FAULT_NONE) else $error("spurious fault");
  AST_HI_LAMP: assert property ($stable(highIdleSw)[*5] |-> panel_q.highIdleLamp == highIdleSw)
    else $error("high idle lamp wrong");
  AST_HI_TARGET: assert property ((highIdleSw && $stable(highIdlePot))[*5]
    |-> speedTarget_q == highIdlePot) else $error("high idle target wrong");
  AST_TRIM_STEP: assert property ($changed(trim1_q) |-> (trim1_q == $past(trim1_q) + 16'h0001)
    || (trim1_q == $past(trim1_q) - 16'h0001)) else $error("trim moved by more than one");
endmodule

bind rcfc_sequencer rcfc_seq_chk i_chk
(
  .clk,
  .sys_rst,
  .highIdleSw,
  .highIdlePot,
  .rpmDataSeen,
  .pressLow,
  .panel_q,
  .speedCmd_q,
  .speedTarget_q,
  .trim1_q,
  .faultCode_q
);

`default_nettype wire

/* File: testbench/tb_top.sv */
`timescale 1ns/100ps
`default_nettype none

module tb_top;
  localparam logic [5:0] B_IDLE = 6'h20;
  localparam logic [5:0] B_PRE  = 6'h10;
  localparam logic [5:0] B_INC  = 6'h08;
  localparam logic [5:0] B_DEC  = 6'h04;
  localparam logic [5:0] B_MODE = 6'h02;
  localparam logic [5:0] B_RPM  = 6'h01;
  localparam int unsigned HOLD_CYC = 12;

  logic                  clk = 1'b0;
  logic                  sys_rst = 1'b1;
  rcfc_pkg::rcfc_btn_t   btnRaw = '0;
  logic                  highIdleSw = 1'b0;
  logic [15:0]           highIdlePot = 16'h0000;
  logic                  dropData = 1'b0;
  logic                  weakPump = 1'b0;
  wire logic             rpmDataSeen;
  wire logic             pressLow;
  rcfc_pkg::rcfc_panel_t panel_q;
  rcfc_pkg::rcfc_speed_t speedCmd_q;
  logic [15:0]           speedTarget_q;
  logic [15:0]           trim1_q;
  logic [15:0]           trim2_q;
  logic [3:0]            faultCode_q;
  int                    n_fail = 0;
  int                    checked = 0;

  always #50 clk = ~clk;

  rcfc_ecu_model i_rcfc_ecu_model
  (
    .clk         (clk),
    .sys_rst     (sys_rst),
    .dropData    (dropData),
    .weakPump    (weakPump),
    .rpmDataSeen (rpmDataSeen),
    .pressLow    (pressLow)
  );

  // Short timings keep the run brief; the real ones only widen the counts
  rcfc_sequencer
  #(
    .DEBOUNCE_CYC     (8),
    .DOUBLE_GAP_CYC   (40),
    .ARM_TIMEOUT_CYC  (100),
    .STEP_TIMEOUT_CYC (200)
  )
  i_rcfc_sequencer
  (
    .clk           (clk),
    .sys_rst       (sys_rst),
    .btnRaw        (btnRaw),
    .highIdleSw    (highIdleSw),
    .highIdlePot   (highIdlePot),
    .rpmDataSeen   (rpmDataSeen),
    .pressLow      (pressLow),
    .panel_q       (panel_q),
    .speedCmd_q    (speedCmd_q),
    .speedTarget_q (speedTarget_q),
    .trim1_q       (trim1_q),
    .trim2_q       (trim2_q),
    .faultCode_q   (faultCode_q)
  );

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // Held and released past the debounce time so each press counts once
  task automatic press(input logic [5:0] m);
    btnRaw = m;
    repeat (HOLD_CYC) @(negedge clk);
    btnRaw = '0;
    repeat (HOLD_CYC) @(negedge clk);
  endtask

  task automatic stop_test();
    $display("Checks %0d, mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_mode();
    chk(16'(panel_q), 16'h0004);
    press(B_MODE);
    chk(16'(panel_q.rpmMode), 16'h0001);
    press(B_MODE);
    chk(16'(panel_q.pressMode), 16'h0001);
    press(B_RPM);
    chk(16'(panel_q), 16'h0002);
  endtask

  task automatic t_cal();
    press(B_IDLE);
    press(B_IDLE);
    chk(16'(panel_q), 16'h001A);
    press(B_IDLE);
    press(B_IDLE);
    chk(16'(panel_q), 16'h0012);
    press(B_PRE);
    chk(16'(panel_q.code), 16'(rcfc_pkg::DISP_SET1));
    chk(16'(speedCmd_q), 16'(rcfc_pkg::SPD_CAL1));
    press(B_PRE);
    chk(16'(panel_q.code), 16'(rcfc_pkg::DISP_RPM));
    press(B_INC);
    press(B_INC);
    press(B_DEC);
    chk(trim1_q, 16'h0001);
    press(B_PRE);
    chk(16'(panel_q.code), 16'(rcfc_pkg::DISP_SET2));
    chk(16'(speedCmd_q), 16'(rcfc_pkg::SPD_CAL2));
    press(B_PRE);
    chk(16'(panel_q.code), 16'(rcfc_pkg::DISP_RPM));
    press(B_DEC);
    chk(trim2_q, 16'hFFFF);
    press(B_PRE);
    chk(16'(panel_q.code), 16'(rcfc_pkg::DISP_NORMAL));
    chk(16'(speedCmd_q), 16'(rcfc_pkg::SPD_IDLE));
    chk(trim1_q, 16'h0001);
  endtask

  task automatic t_timeout();
    press(B_IDLE);
    repeat (60) @(negedge clk);
    press(B_IDLE);
    chk(16'(panel_q.code), 16'(rcfc_pkg::DISP_NORMAL));
    repeat (60) @(negedge clk);
    press(B_IDLE);
    press(B_IDLE);
    chk(16'(panel_q.flash), 16'h0001);
    repeat (120) @(negedge clk);
    chk(16'(panel_q.code), 16'(rcfc_pkg::DISP_NORMAL));
    chk(16'(panel_q.flash), 16'h0000);
    press(B_IDLE);
    press(B_IDLE);
    press(B_IDLE);
    press(B_IDLE);
    press(B_PRE);
    press(B_MODE);
    chk(16'(panel_q.rpmMode), 16'h0001);
    chk(16'(panel_q.code), 16'(rcfc_pkg::DISP_SET1));
    repeat (220) @(negedge clk);
    chk(16'(panel_q.code), 16'(rcfc_pkg::DISP_NORMAL));
    chk(16'(speedCmd_q), 16'(rcfc_pkg::SPD_IDLE));
  endtask

  task automatic t_fault();
    dropData = 1'b1;
    weakPump = 1'b1;
    repeat (10) @(negedge clk);
    chk(16'(faultCode_q), 16'(rcfc_pkg::FAULT_NO_RPM));
    dropData = 1'b0;
    repeat (10) @(negedge clk);
    chk(16'(faultCode_q), 16'(rcfc_pkg::FAULT_NO_PRESS));
    weakPump = 1'b0;
    repeat (10) @(negedge clk);
    chk(16'(faultCode_q), 16'(rcfc_pkg::FAULT_NONE));
  endtask

  task automatic t_high();
    highIdlePot = 16'h0ABC;
    highIdleSw = 1'b1;
    repeat (10) @(negedge clk);
    chk(16'(panel_q.highIdleLamp), 16'h0001);
    chk(16'(speedCmd_q), 16'(rcfc_pkg::SPD_HIGH_IDLE));
    chk(speedTarget_q, 16'h0ABC);
    highIdleSw = 1'b0;
    repeat (10) @(negedge clk);
    chk(16'(panel_q.highIdleLamp), 16'h0000);
    chk(16'(speedCmd_q), 16'(rcfc_pkg::SPD_IDLE));
  endtask

  initial
  begin
    repeat (4) @(negedge clk);
    sys_rst = 1'b0;
    repeat (10) @(negedge clk);
    t_mode();
    t_cal();
    t_timeout();
    t_fault();
    t_high();
    stop_test();
  end
endmodule

`default_nettype wire
